// file: hbat_bridge.sv
// Bridge end: arbitration, master transfers and slave termination
`timescale 1ns/1ps
`include "hbat_defines.svh"
// Behaviour
// - Strap high in PCI reset sets master-enable
// - Request bus when mastering is needed
// - Request changes only after clock edges
// - Arbitrate with request, grant, busy lines
// - Master holds transfer-in-progress for whole transfer
// - PCI select means forward to PCI
// - Register select means serve registers internally
// - Slave ends normal cycles with acknowledge
// - Negate acknowledge before releasing it
// - Acknowledge plus error together means retry
// - Addressed slave acknowledges bridge master transfers
// - 32-bit data bus tristated when idle
// - Assert busy after clock edge while master
// - Sample grant on rising clock edges
// - Read/write high read, low write
module hbat_bridge #(
  parameter int DATA_W = `HBAT_DATA_W
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_pci_reset,
  hbat_if.dev bus,
  input wire logic i_mst_req,
  input wire logic i_mst_read,
  input wire logic [DATA_W-1:0] i_mst_wdata,
  output logic o_mst_done,
  output logic o_mst_retry,
  output logic o_mst_error,
  output logic [DATA_W-1:0] o_mst_rdata,
  output logic o_master_enable,
  input wire logic i_slv_ready,
  input wire hbat_pkg::hbat_term_t i_slv_term,
  input wire logic [DATA_W-1:0] i_slv_rdata,
  output logic o_slv_reg_access,
  output logic o_slv_pci_access,
  output logic o_slv_read,
  output logic [DATA_W-1:0] o_slv_wdata
);
  import hbat_pkg::*;
  hbat_mst_t m_q;
  hbat_slv_t s_q;
  hbat_term_t term_q;
  logic grant_q, sel_pci_q;
  logic [DATA_W-1:0] wdata_q;
  logic read_q;

  // ****************
  // Strap capture
  // ****************
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_master_enable <= 1'b0;
    end else if (i_pci_reset && bus.master_enable_strap) begin
      o_master_enable <= 1'b1;
    end
  end

  // ****************
  // Master side
  // ****************
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      grant_q <= 1'b0;
    end else begin
      grant_q <= !bus.bus_grant_n;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      m_q <= HBAT_M_IDLE;
      read_q <= 1'b1;
      wdata_q <= '0;
    end else begin
      case (m_q)
        HBAT_M_IDLE: begin
          if (i_mst_req && o_master_enable) begin
            m_q <= HBAT_M_REQ;
            read_q <= i_mst_read;
            wdata_q <= i_mst_wdata;
          end
        end
        HBAT_M_REQ: begin
          if (grant_q && bus.grant_ack_n) begin
            m_q <= HBAT_M_OWN;
          end
        end
        HBAT_M_OWN: m_q <= HBAT_M_XFER;
        HBAT_M_XFER: begin
          if (!bus.transfer_ack_n || !bus.transfer_error_ack_n) begin
            m_q <= HBAT_M_DONE;
          end
        end
        HBAT_M_DONE: m_q <= HBAT_M_IDLE;
        default: m_q <= HBAT_M_IDLE;
      endcase
    end
  end

  // Pin drivers, all registered after a clock edge
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      bus.bus_request_n <= 1'b1;
    end else begin
      bus.bus_request_n <= !((m_q == HBAT_M_IDLE && i_mst_req && o_master_enable)
        || (m_q == HBAT_M_REQ && !(grant_q && bus.grant_ack_n)));
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      bus.busy_dev_o <= 1'b1;
      bus.busy_dev_oe_n <= 1'b1;
      bus.tip_dev_o <= 1'b1;
      bus.tip_dev_oe_n <= 1'b1;
      bus.rw_dev_o <= 1'b1;
      bus.rw_dev_oe_n <= 1'b1;
      bus.d_dev_oe_n <= 1'b1;
    end else begin
      // Busy driven only once owning, negated for one cycle before release
      bus.busy_dev_o <= !(m_q == HBAT_M_OWN || m_q == HBAT_M_XFER
        || (m_q == HBAT_M_REQ && grant_q && bus.grant_ack_n));
      bus.busy_dev_oe_n <= !(m_q == HBAT_M_OWN || m_q == HBAT_M_XFER || m_q == HBAT_M_DONE
        || (m_q == HBAT_M_REQ && grant_q && bus.grant_ack_n));
      bus.tip_dev_o <= !((m_q == HBAT_M_OWN) || (m_q == HBAT_M_XFER
        && bus.transfer_ack_n && bus.transfer_error_ack_n));
      bus.tip_dev_oe_n <= (m_q == HBAT_M_IDLE) || (m_q == HBAT_M_REQ);
      bus.rw_dev_o <= read_q;
      bus.rw_dev_oe_n <= !(m_q == HBAT_M_OWN || m_q == HBAT_M_XFER);
      bus.d_dev_oe_n <= !((m_q == HBAT_M_OWN || m_q == HBAT_M_XFER) && !read_q
        || s_q == HBAT_S_WAIT && i_slv_ready && o_slv_read);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_mst_done <= 1'b0;
      o_mst_retry <= 1'b0;
      o_mst_error <= 1'b0;
      o_mst_rdata <= '0;
    end else begin
      o_mst_done <= 1'b0;
      o_mst_retry <= 1'b0;
      o_mst_error <= 1'b0;
      if (m_q == HBAT_M_XFER) begin
        if (!bus.transfer_ack_n && !bus.transfer_error_ack_n) begin
          o_mst_retry <= 1'b1;
        end else if (!bus.transfer_error_ack_n) begin
          o_mst_error <= 1'b1;
        end else if (!bus.transfer_ack_n) begin
          o_mst_done <= 1'b1;
          if (read_q) begin
            o_mst_rdata <= bus.data;
          end
        end
      end
    end
  end

  // ****************
  // Slave side
  // ****************
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      s_q <= HBAT_S_IDLE;
      sel_pci_q <= 1'b0;
      term_q <= HBAT_TERM_NONE;
      o_slv_reg_access <= 1'b0;
      o_slv_pci_access <= 1'b0;
      o_slv_read <= 1'b1;
      o_slv_wdata <= '0;
    end else begin
      o_slv_reg_access <= 1'b0;
      o_slv_pci_access <= 1'b0;
      case (s_q)
        HBAT_S_IDLE: begin
          if (!bus.transfer_in_progress_n && m_q == HBAT_M_IDLE
              && (!bus.pci_select_n || !bus.register_select_n)) begin
            s_q <= HBAT_S_WAIT;
            sel_pci_q <= !bus.pci_select_n;
            o_slv_pci_access <= !bus.pci_select_n;
            o_slv_reg_access <= bus.pci_select_n;
            o_slv_read <= bus.rw;
            o_slv_wdata <= bus.data;
          end
        end
        HBAT_S_WAIT: begin
          if (i_slv_ready) begin
            s_q <= HBAT_S_TERM;
            term_q <= (i_slv_term == HBAT_TERM_NONE) ? HBAT_TERM_ACK : i_slv_term;
          end
        end
        HBAT_S_TERM: s_q <= HBAT_S_NEG;
        HBAT_S_NEG: s_q <= HBAT_S_IDLE;
        default: s_q <= HBAT_S_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      bus.ta_dev_o <= 1'b1;
      bus.ta_dev_oe_n <= 1'b1;
      bus.tea_dev_o <= 1'b1;
      bus.tea_dev_oe_n <= 1'b1;
      bus.d_dev_o <= '0;
    end else begin
      bus.ta_dev_o <= !(s_q == HBAT_S_WAIT && i_slv_ready
        && i_slv_term != HBAT_TERM_ERR);
      bus.tea_dev_o <= !(s_q == HBAT_S_WAIT && i_slv_ready
        && (i_slv_term == HBAT_TERM_ERR || i_slv_term == HBAT_TERM_RETRY));
      bus.ta_dev_oe_n <= !(s_q == HBAT_S_WAIT || s_q == HBAT_S_TERM);
      bus.tea_dev_oe_n <= !(s_q == HBAT_S_WAIT || s_q == HBAT_S_TERM);
      if (m_q == HBAT_M_REQ) begin
        bus.d_dev_o <= wdata_q;
      end else if (s_q == HBAT_S_WAIT && i_slv_ready) begin
        bus.d_dev_o <= i_slv_rdata;
      end
    end
  end
endmodule

// file: hbat_defines.svh
// Timing and width constants for the host-bus arbitration and termination link
`ifndef HBAT_DEFINES_SVH
`define HBAT_DEFINES_SVH
`define HBAT_DATA_W 32
`define HBAT_ACK_NEG_CYCLES 1
`define HBAT_WAIT_CYCLES_DEF 2
`endif

// file: hbat_host.sv
// Host end: arbiter, decoder, master cycles and slave acknowledge
`timescale 1ns/1ps
`include "hbat_defines.svh"
module hbat_host #(
  parameter int DATA_W = `HBAT_DATA_W
) (
  input wire logic i_clk,
  input wire logic i_reset,
  hbat_if.host bus,
  input wire logic i_strap,
  input wire logic i_cyc_req,
  input wire logic i_cyc_pci,
  input wire logic i_cyc_read,
  input wire logic [DATA_W-1:0] i_cyc_wdata,
  output logic o_cyc_done,
  output logic o_cyc_retry,
  output logic o_cyc_error,
  output logic [DATA_W-1:0] o_cyc_rdata,
  input wire hbat_pkg::hbat_term_t i_slv_term,
  output logic o_slv_wr,
  output logic [DATA_W-1:0] o_slv_wdata
);
  import hbat_pkg::*;
  typedef enum logic [1:0] {
    HBAT_H_IDLE = 2'b00,
    HBAT_H_ADDR = 2'b01,
    HBAT_H_WAIT = 2'b10
  } hbat_hst_t;
  hbat_hst_t h_q;
  logic granted_q, term_phase_q;

  // ****************
  // Arbiter
  // ****************
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      bus.bus_grant_n <= 1'b1;
      granted_q <= 1'b0;
      bus.master_enable_strap <= 1'b0;
    end else begin
      bus.master_enable_strap <= i_strap;
      if (!granted_q && !bus.bus_request_n && h_q == HBAT_H_IDLE && !i_cyc_req) begin
        bus.bus_grant_n <= 1'b0;
        granted_q <= 1'b1;
      end else if (granted_q && !bus.grant_ack_n) begin
        bus.bus_grant_n <= 1'b1;
      end else if (granted_q && bus.bus_grant_n && bus.grant_ack_n
                   && bus.bus_request_n) begin
        granted_q <= 1'b0;
      end
    end
  end

  // ****************
  // Host master cycles
  // ****************
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      h_q <= HBAT_H_IDLE;
      bus.tip_host_o <= 1'b1;
      bus.tip_host_oe_n <= 1'b1;
      bus.rw_host_o <= 1'b1;
      bus.rw_host_oe_n <= 1'b1;
      bus.d_host_o <= '0;
      bus.pci_select_n <= 1'b1;
      bus.register_select_n <= 1'b1;
      bus.busy_host_o <= 1'b1;
      bus.busy_host_oe_n <= 1'b1;
      o_cyc_done <= 1'b0;
      o_cyc_retry <= 1'b0;
      o_cyc_error <= 1'b0;
      o_cyc_rdata <= '0;
    end else begin
      o_cyc_done <= 1'b0;
      o_cyc_retry <= 1'b0;
      o_cyc_error <= 1'b0;
      case (h_q)
        HBAT_H_IDLE: begin
          if (i_cyc_req && !granted_q && bus.grant_ack_n) begin
            h_q <= HBAT_H_ADDR;
            bus.tip_host_o <= 1'b0;
            bus.tip_host_oe_n <= 1'b0;
            bus.rw_host_o <= i_cyc_read;
            bus.rw_host_oe_n <= 1'b0;
            bus.d_host_o <= i_cyc_wdata;
            bus.pci_select_n <= !i_cyc_pci;
            bus.register_select_n <= i_cyc_pci;
            bus.busy_host_o <= 1'b0;
            bus.busy_host_oe_n <= 1'b0;
          end else if (!bus.transfer_in_progress_n) begin
            bus.d_host_o <= i_cyc_wdata;
          end
        end
        HBAT_H_ADDR: h_q <= HBAT_H_WAIT;
        HBAT_H_WAIT: begin
          if (!bus.transfer_ack_n || !bus.transfer_error_ack_n) begin
            h_q <= HBAT_H_IDLE;
            o_cyc_retry <= !bus.transfer_ack_n && !bus.transfer_error_ack_n;
            o_cyc_error <= bus.transfer_ack_n;
            o_cyc_done <= !bus.transfer_ack_n && bus.transfer_error_ack_n;
            o_cyc_rdata <= bus.data;
            bus.tip_host_o <= 1'b1;
            bus.tip_host_oe_n <= 1'b1;
            bus.rw_host_oe_n <= 1'b1;
            bus.pci_select_n <= 1'b1;
            bus.register_select_n <= 1'b1;
            bus.busy_host_o <= 1'b1;
            bus.busy_host_oe_n <= 1'b1;
          end
        end
        default: h_q <= HBAT_H_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      bus.d_host_oe_n <= 1'b1;
    end else begin
      bus.d_host_oe_n <= !((h_q == HBAT_H_IDLE && i_cyc_req && !granted_q && bus.grant_ack_n
        && !i_cyc_read) || (h_q != HBAT_H_IDLE && !bus.rw_host_o
        && !(h_q == HBAT_H_WAIT && !bus.transfer_ack_n))
        || (h_q == HBAT_H_IDLE && !bus.transfer_in_progress_n && bus.rw && !term_phase_q
        && bus.ta_host_o));
    end
  end

  // ****************
  // Slave answering bridge master cycles
  // ****************
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      term_phase_q <= 1'b0;
      bus.ta_host_o <= 1'b1;
      bus.ta_host_oe_n <= 1'b1;
      bus.tea_host_o <= 1'b1;
      bus.tea_host_oe_n <= 1'b1;
      o_slv_wr <= 1'b0;
      o_slv_wdata <= '0;
    end else begin
      o_slv_wr <= 1'b0;
      bus.ta_host_o <= 1'b1;
      bus.tea_host_o <= 1'b1;
      term_phase_q <= 1'b0;
      if (!bus.transfer_in_progress_n && h_q == HBAT_H_IDLE && !term_phase_q
          && bus.ta_host_o) begin
        term_phase_q <= 1'b1;
        bus.ta_host_o <= (i_slv_term == HBAT_TERM_ERR);
        bus.tea_host_o <= !(i_slv_term == HBAT_TERM_ERR || i_slv_term == HBAT_TERM_RETRY);
        bus.ta_host_oe_n <= 1'b0;
        bus.tea_host_oe_n <= 1'b0;
        o_slv_wr <= !bus.rw;
        o_slv_wdata <= bus.data;
      end else if (!term_phase_q) begin
        bus.ta_host_oe_n <= 1'b1;
        bus.tea_host_oe_n <= 1'b1;
      end
    end
  end
endmodule

// file: hbat_if.sv
// Host-bus pins shared by the bridge end and the host end
`timescale 1ns/1ps
`include "hbat_defines.svh"
interface hbat_if;
  logic bus_request_n;
  logic bus_grant_n;
  logic busy_dev_o, busy_dev_oe_n, busy_host_o, busy_host_oe_n;
  logic tip_dev_o, tip_dev_oe_n, tip_host_o, tip_host_oe_n;
  logic pci_select_n;
  logic register_select_n;
  logic rw_dev_o, rw_dev_oe_n, rw_host_o, rw_host_oe_n;
  logic ta_dev_o, ta_dev_oe_n, ta_host_o, ta_host_oe_n;
  logic tea_dev_o, tea_dev_oe_n, tea_host_o, tea_host_oe_n;
  logic [`HBAT_DATA_W-1:0] d_dev_o, d_host_o;
  logic d_dev_oe_n, d_host_oe_n;
  logic master_enable_strap;
  // Resolved wired levels, pulled high when undriven
  logic grant_ack_n, transfer_in_progress_n, rw, transfer_ack_n, transfer_error_ack_n;
  logic [`HBAT_DATA_W-1:0] data;
  assign grant_ack_n = (!busy_dev_oe_n ? busy_dev_o : 1'b1) & (!busy_host_oe_n ? busy_host_o : 1'b1);
  assign transfer_in_progress_n = (!tip_dev_oe_n ? tip_dev_o : 1'b1)
    & (!tip_host_oe_n ? tip_host_o : 1'b1);
  assign rw = (!rw_dev_oe_n ? rw_dev_o : 1'b1) & (!rw_host_oe_n ? rw_host_o : 1'b1);
  assign transfer_ack_n = (!ta_dev_oe_n ? ta_dev_o : 1'b1) & (!ta_host_oe_n ? ta_host_o : 1'b1);
  assign transfer_error_ack_n = (!tea_dev_oe_n ? tea_dev_o : 1'b1)
    & (!tea_host_oe_n ? tea_host_o : 1'b1);
  assign data = !d_dev_oe_n ? d_dev_o : (!d_host_oe_n ? d_host_o : '1);
  modport dev (
    output bus_request_n, busy_dev_o, busy_dev_oe_n, tip_dev_o, tip_dev_oe_n,
    output rw_dev_o, rw_dev_oe_n, ta_dev_o, ta_dev_oe_n, tea_dev_o, tea_dev_oe_n,
    output d_dev_o, d_dev_oe_n,
    input bus_grant_n, pci_select_n, register_select_n, master_enable_strap,
    input grant_ack_n, transfer_in_progress_n, rw, transfer_ack_n, transfer_error_ack_n, data
  );
  modport host (
    output bus_grant_n, busy_host_o, busy_host_oe_n, tip_host_o, tip_host_oe_n,
    output rw_host_o, rw_host_oe_n, ta_host_o, ta_host_oe_n, tea_host_o, tea_host_oe_n,
    output d_host_o, d_host_oe_n, pci_select_n, register_select_n, master_enable_strap,
    input bus_request_n, grant_ack_n, transfer_in_progress_n, rw, transfer_ack_n,
    input transfer_error_ack_n, data
  );
endinterface

// file: hbat_link_sva.sv
// Protocol checker for the host-bus link between bridge and host ends
`timescale 1ns/1ps
module hbat_link_sva (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic bus_request_n,
  input wire logic bus_grant_n,
  input wire logic busy_dev_oe_n,
  input wire logic transfer_in_progress_n,
  input wire logic transfer_ack_n,
  input wire logic transfer_error_ack_n,
  input wire logic ta_dev_o,
  input wire logic ta_dev_oe_n,
  input wire logic pci_select_n,
  input wire logic register_select_n,
  input wire logic d_dev_oe_n,
  input wire logic d_host_oe_n
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  // ****
  // Arbitration
  // ****
  chk_grant_after_req: assert property (
    $fell(bus_grant_n) |-> !$past(bus_request_n)) else $error("grant without request");
  chk_req_held_own: assert property (
    !bus_request_n && busy_dev_oe_n |=> !bus_request_n || !busy_dev_oe_n)
    else $error("request dropped before ownership");
  chk_req_gets_bus: assert property (
    $fell(bus_request_n) |-> ##[1:40] $fell(busy_dev_oe_n)) else $error("no ownership");
  chk_busy_after_grant: assert property (
    $fell(busy_dev_oe_n) |-> !$past(bus_grant_n) || !$past(bus_grant_n, 2))
    else $error("busy taken without grant");
  // ****
  // Transfer and termination
  // ****
  chk_tip_whole_xfer: assert property (
    $fell(transfer_in_progress_n) |-> !transfer_in_progress_n throughout
    ##[0:40] (!transfer_ack_n || !transfer_error_ack_n)) else $error("tip dropped early");
  chk_ack_one_cycle: assert property (
    !ta_dev_oe_n && !ta_dev_o |=> ta_dev_o && !ta_dev_oe_n) else $error("ack not negated");
  chk_ack_neg_release: assert property (
    $rose(ta_dev_oe_n) |-> $past(ta_dev_o) && !$past(ta_dev_oe_n))
    else $error("ack released while asserted");
  chk_selects_exclusive: assert property (
    pci_select_n || register_select_n) else $error("both selects asserted");
  chk_data_one_driver: assert property (
    d_dev_oe_n || d_host_oe_n) else $error("data driven by both ends");
  cov_bridge_owns: cover property ($fell(busy_dev_oe_n));
  cov_retry_seen: cover property (!transfer_ack_n && !transfer_error_ack_n);
  cov_bridge_acks: cover property (!ta_dev_oe_n && !ta_dev_o);
endmodule

// file: hbat_pkg.sv
// Types shared by both ends of the host-bus link
package hbat_pkg;
  typedef enum logic [1:0] {
    HBAT_TERM_NONE = 2'b00,
    HBAT_TERM_ACK = 2'b01,
    HBAT_TERM_ERR = 2'b10,
    HBAT_TERM_RETRY = 2'b11
  } hbat_term_t;
  typedef enum logic [2:0] {
    HBAT_M_IDLE = 3'b000,
    HBAT_M_REQ = 3'b001,
    HBAT_M_OWN = 3'b010,
    HBAT_M_XFER = 3'b011,
    HBAT_M_DONE = 3'b100
  } hbat_mst_t;
  typedef enum logic [1:0] {
    HBAT_S_IDLE = 2'b00,
    HBAT_S_WAIT = 2'b01,
    HBAT_S_TERM = 2'b10,
    HBAT_S_NEG = 2'b11
  } hbat_slv_t;
endpackage

// file: testbench.sv
// Self-checking bench joining the bridge end and the host end
`timescale 1ns/1ps
module testbench;
  import hbat_pkg::*;
  logic i_clk = 1'b0;
  logic i_reset = 1'b1;
  logic pci_reset = 1'b0;
  logic b_mst_req = 1'b0;
  logic b_mst_read = 1'b0;
  logic [31:0] b_mst_wdata = 32'h0000_0000;
  logic b_mst_done, b_mst_retry, b_mst_error, b_master_enable;
  logic [31:0] b_mst_rdata, b_slv_wdata, h_cyc_rdata, h_slv_wdata;
  logic b_slv_ready = 1'b0;
  hbat_term_t b_slv_term = HBAT_TERM_ACK;
  logic [31:0] b_slv_rdata = 32'h0000_0000;
  logic b_slv_reg_access, b_slv_pci_access, b_slv_read;
  logic h_strap = 1'b0;
  logic h_cyc_req = 1'b0;
  logic h_cyc_pci = 1'b0;
  logic h_cyc_read = 1'b0;
  logic [31:0] h_cyc_wdata = 32'h0000_0000;
  logic h_cyc_done, h_cyc_retry, h_cyc_error, h_slv_wr;
  hbat_term_t h_slv_term = HBAT_TERM_ACK;
  int mismatches = 0;
  int total_checks = 0;
  hbat_if bus();
  hbat_bridge u_hbat_bridge (.i_clk(i_clk), .i_reset(i_reset), .i_pci_reset(pci_reset),
    .bus(bus), .i_mst_req(b_mst_req), .i_mst_read(b_mst_read), .i_mst_wdata(b_mst_wdata),
    .o_mst_done(b_mst_done), .o_mst_retry(b_mst_retry), .o_mst_error(b_mst_error),
    .o_mst_rdata(b_mst_rdata), .o_master_enable(b_master_enable), .i_slv_ready(b_slv_ready),
    .i_slv_term(b_slv_term), .i_slv_rdata(b_slv_rdata), .o_slv_reg_access(b_slv_reg_access),
    .o_slv_pci_access(b_slv_pci_access), .o_slv_read(b_slv_read), .o_slv_wdata(b_slv_wdata));
  hbat_host u_hbat_host (.i_clk(i_clk), .i_reset(i_reset), .bus(bus), .i_strap(h_strap),
    .i_cyc_req(h_cyc_req), .i_cyc_pci(h_cyc_pci), .i_cyc_read(h_cyc_read),
    .i_cyc_wdata(h_cyc_wdata), .o_cyc_done(h_cyc_done), .o_cyc_retry(h_cyc_retry),
    .o_cyc_error(h_cyc_error), .o_cyc_rdata(h_cyc_rdata), .i_slv_term(h_slv_term),
    .o_slv_wr(h_slv_wr), .o_slv_wdata(h_slv_wdata));
  hbat_link_sva u_hbat_link_sva (.i_clk(i_clk), .i_reset(i_reset),
    .bus_request_n(bus.bus_request_n), .bus_grant_n(bus.bus_grant_n),
    .busy_dev_oe_n(bus.busy_dev_oe_n), .transfer_in_progress_n(bus.transfer_in_progress_n),
    .transfer_ack_n(bus.transfer_ack_n), .transfer_error_ack_n(bus.transfer_error_ack_n),
    .ta_dev_o(bus.ta_dev_o), .ta_dev_oe_n(bus.ta_dev_oe_n), .pci_select_n(bus.pci_select_n),
    .register_select_n(bus.register_select_n), .d_dev_oe_n(bus.d_dev_oe_n),
    .d_host_oe_n(bus.d_host_oe_n));
  always #5 i_clk = ~i_clk;
  // ****
  // Checking and closing
  // ****
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("Checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // ****
  // Scenarios
  // ****
  task automatic strap_and_refusal();
    check("idle_data", bus.data, 32'hFFFF_FFFF);
    b_mst_req = 1'b1;
    repeat (10) @(negedge i_clk);
    check("req_refused", bus.bus_request_n, 1'b1);
    b_mst_req = 1'b0;
    pci_reset = 1'b1;
    repeat (3) @(negedge i_clk);
    pci_reset = 1'b0;
    repeat (2) @(negedge i_clk);
    check("enable_low", b_master_enable, 1'b0);
    h_strap = 1'b1;
    pci_reset = 1'b1;
    repeat (4) @(negedge i_clk);
    pci_reset = 1'b0;
    h_strap = 1'b0;
    repeat (3) @(negedge i_clk);
    check("enable_set", b_master_enable, 1'b1);
  endtask
  task automatic bridge_master(input logic rd, input logic [31:0] wd, input hbat_term_t t);
    int n;
    logic wr_seen, rw_seen;
    logic [31:0] wd_seen;
    wr_seen = 1'b0;
    rw_seen = 1'bx;
    wd_seen = 32'h0000_0000;
    @(negedge i_clk);
    b_mst_read = rd;
    b_mst_wdata = wd;
    h_cyc_wdata = ~wd;
    h_slv_term = t;
    b_mst_req = 1'b1;
    for (n = 0; n < 60 && !(b_mst_done || b_mst_retry || b_mst_error); n++) begin
      @(negedge i_clk);
      if (bus.transfer_in_progress_n === 1'b0) rw_seen = bus.rw;
      if (h_slv_wr === 1'b1) begin
        wr_seen = 1'b1;
        wd_seen = h_slv_wdata;
      end
    end
    check("mst_done", b_mst_done, t == HBAT_TERM_ACK || t == HBAT_TERM_NONE);
    check("mst_retry", b_mst_retry, t == HBAT_TERM_RETRY);
    check("mst_error", b_mst_error, t == HBAT_TERM_ERR);
    check("mst_rw", rw_seen, rd);
    if (rd && t == HBAT_TERM_ACK) check("mst_rdata", b_mst_rdata, ~wd);
    if (!rd && t == HBAT_TERM_ACK) begin
      check("slv_wr", wr_seen, 1'b1);
      check("slv_wdata", wd_seen, wd);
    end
    b_mst_req = 1'b0;
    repeat (4) @(negedge i_clk);
  endtask
  task automatic host_cycle(input logic pci, input logic rd, input logic [31:0] wd,
      input hbat_term_t t);
    int n;
    @(negedge i_clk);
    h_cyc_pci = pci;
    h_cyc_read = rd;
    h_cyc_wdata = wd;
    b_slv_term = t;
    b_slv_rdata = ~wd;
    h_cyc_req = 1'b1;
    for (n = 0; n < 30 && !(b_slv_reg_access || b_slv_pci_access); n++) @(negedge i_clk);
    check("reg_access", b_slv_reg_access, !pci);
    check("pci_access", b_slv_pci_access, pci);
    check("slv_read", b_slv_read, rd);
    if (!rd) check("slv_wdata", b_slv_wdata, wd);
    b_slv_ready = 1'b1;
    @(negedge i_clk);
    b_slv_ready = 1'b0;
    for (n = 0; n < 30 && !(h_cyc_done || h_cyc_retry || h_cyc_error); n++) @(negedge i_clk);
    check("cyc_done", h_cyc_done, t == HBAT_TERM_ACK || t == HBAT_TERM_NONE);
    check("cyc_retry", h_cyc_retry, t == HBAT_TERM_RETRY);
    check("cyc_error", h_cyc_error, t == HBAT_TERM_ERR);
    if (rd && h_cyc_done === 1'b1) check("cyc_rdata", h_cyc_rdata, ~wd);
    h_cyc_req = 1'b0;
    repeat (4) @(negedge i_clk);
    check("ta_released", bus.transfer_ack_n, 1'b1);
  endtask
  initial begin
    repeat (4) @(negedge i_clk);
    i_reset = 1'b0;
    @(negedge i_clk);
    strap_and_refusal();
    bridge_master(1'b0, 32'hA5C3_0F1E, HBAT_TERM_ACK);
    bridge_master(1'b1, 32'h5A5A_0F0F, HBAT_TERM_ACK);
    bridge_master(1'b0, 32'h1234_5678, HBAT_TERM_RETRY);
    bridge_master(1'b1, 32'h0000_0000, HBAT_TERM_ERR);
    host_cycle(1'b0, 1'b1, 32'h3C3C_5A5A, HBAT_TERM_ACK);
    host_cycle(1'b1, 1'b0, 32'hDEAD_0001, HBAT_TERM_RETRY);
    host_cycle(1'b0, 1'b0, 32'h8000_0001, HBAT_TERM_ERR);
    host_cycle(1'b1, 1'b1, 32'h0F0F_F0F0, HBAT_TERM_NONE);
    report_and_stop();
  end
  initial begin
    #50000;
    mismatches++;
    report_and_stop();
  end
endmodule
